// file: include/mbs_pkg.sv
package mbs_pkg;

    // System clock and line bit rates
    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned BAUD_2400   = 2400;
    localparam int unsigned BAUD_4800   = 4800;
    localparam int unsigned BAUD_9600   = 9600;
    localparam int unsigned BAUD_19200  = 19200;
    localparam int unsigned BAUD_38400  = 38400;
    localparam int unsigned BAUD_57600  = 57600;
    localparam int unsigned BAUD_115200 = 115200;

    // Character and silence framing
    localparam int unsigned CHAR_BITS       = 11;
    localparam int unsigned SIL_HALF_CHARS  = 7;     // 3.5 characters counted in halves
    localparam logic [3:0]  RX_STOP_BIT     = 4'h9;
    localparam logic [3:0]  TX_FRAME_BITS   = 4'hA;

    // Station numbers
    localparam logic [7:0]  STATION_OFF     = 8'hF8;
    localparam logic [7:0]  STATION_MIN     = 8'h01;
    localparam logic [7:0]  STATION_MAX     = 8'hF7;

    // Function codes
    localparam logic [7:0]  FN_RD_HOLD      = 8'h03;
    localparam logic [7:0]  FN_RD_INPUT     = 8'h04;
    localparam logic [7:0]  FN_WR_ONE       = 8'h06;
    localparam logic [7:0]  FN_WR_MULTI     = 8'h10;

    // CRC
    localparam logic [15:0] CRC_INIT        = 16'hFFFF;
    localparam logic [15:0] CRC_POLY        = 16'hA001;
    localparam logic [15:0] CRC_RESIDUE     = 16'h0000;

    // Register map and frame sizes
    localparam logic [16:0] REG_SPAN        = 17'h00100;
    localparam logic [16:0] ALT_LIMIT       = 17'h00200;
    localparam logic [15:0] ALT_BASE        = 16'h0100;
    localparam logic [7:0]  CTRL_PARAM_ADDR = 8'h00;
    localparam logic [15:0] MAX_RD_QTY      = 16'h007D;
    localparam logic [15:0] MAX_WR_QTY      = 16'h007B;
    localparam logic [8:0]  RX_BUF_BYTES    = 9'h100;
    localparam logic [8:0]  MIN_FRAME_LEN   = 9'h004;
    localparam logic [8:0]  RD_REQ_LEN      = 9'h008;
    localparam logic [8:0]  WR_RESP_LEN     = 9'h008;
    localparam logic [8:0]  WR_MULTI_HDR    = 9'h009;
    localparam logic [8:0]  RD_RESP_FIX     = 9'h005;
    localparam logic [7:0]  WR_DATA_FIRST   = 8'h07;

    typedef enum logic [2:0] {
        MBS_LISTEN, MBS_CHECK, MBS_APPLY, MBS_LOAD,
        MBS_FETCH, MBS_LATCH, MBS_SEND, MBS_GUARD
    } mbs_state_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [15:0] data;
    } mbs_wr_t;

    typedef struct packed {
        mbs_state_t  st;
        logic        rx_busy;
        logic [15:0] rx_cnt;
        logic [3:0]  rx_bit;
        logic [7:0]  rx_sh;
        logic [23:0] sil_cnt;
        logic [8:0]  rx_len;
        logic        rx_bad;
        logic [15:0] rx_crc;
        logic [7:0]  fn;
        logic [15:0] base;
        logic [15:0] qty;
        logic [7:0]  wi;
        logic        fetched;
        logic [15:0] word;
        logic [7:0]  act_addr;
        logic [8:0]  tx_idx;
        logic [8:0]  resp_len;
        logic [15:0] tx_crc;
        logic [15:0] tx_cnt;
        logic [3:0]  tx_bit;
        logic [9:0]  tx_sh;
        logic        tx_line;
        logic        tx_en;
        mbs_wr_t     wr;
        mbs_wr_t     cmd;
        logic [15:0] rd_data;
    } mbs_regs_t;

    localparam mbs_regs_t MBS_REGS_RST = '{
        st:      MBS_LISTEN,
        rx_crc:  CRC_INIT,
        tx_crc:  CRC_INIT,
        tx_line: 1'b1,
        default: '0
    };

    // Clock cycles per bit for the selected rate
    function automatic logic [15:0] mbs_bit_div(input logic [2:0] sel);
        int unsigned rate;
        rate = BAUD_9600;
        unique case (sel)
            3'h0: rate = BAUD_2400;
            3'h1: rate = BAUD_4800;
            3'h2: rate = BAUD_9600;
            3'h3: rate = BAUD_19200;
            3'h4: rate = BAUD_38400;
            3'h5: rate = BAUD_57600;
            3'h6: rate = BAUD_115200;
            default: rate = BAUD_9600;
        endcase
        return 16'(CLK_HZ / rate);
    endfunction : mbs_bit_div

    // Cycles in 3.5 character times of eleven bits
    function automatic logic [23:0] mbs_sil_lim(input logic [15:0] div);
        return 24'((32'(div) * CHAR_BITS * SIL_HALF_CHARS) / 2);
    endfunction : mbs_sil_lim

    function automatic logic [15:0] mbs_crc_byte(input logic [15:0] crc,
                                                 input logic [7:0]  data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : mbs_crc_byte

endpackage : mbs_pkg

// file: logic/mbs_framer.sv
// Operation
// - 10-bit characters: start, 8 LSB-first, stop
// - Seven selectable bit rates, shared by both ends
// - Half duplex, reply within 20 ms
// - Broadcasts ignored; only own station processed
// - Over 3.5 characters silence frames each message
// - Mid-frame silence discards partial frame
// - Station 1..247; 248 disables communication
// - Station, function, data, then CRC order
// - Only functions 3, 4, 6, 16 accepted
// - Fn4 reads actual data; fn3 settings/alternate
// - Fn6 writes one setting; fn16 several
// - Words sent high byte first
// - CRC appended low byte then high
// - Bad CRC drops frame without reply
// - Actual data at 0..255 and 256..511
// - 256 settings at addresses 0..255
// - Writing setting one issues control command
`timescale 1ns/100ps

module mbs_framer (
    // Clock and reset
    input  wire logic            sys_clk_in,
    input  wire logic            rstn_in,
    // Serial line towards the transceiver
    input  wire logic            rx_in,
    output logic                 tx_out,
    output logic                 tx_en_out,
    // Configuration
    input  wire logic [2:0]      baud_sel_in,
    input  wire logic [7:0]      station_in,
    // Actual-data read port
    output logic [7:0]           act_addr_out,
    input  wire logic [15:0]     act_data_in,
    // Setting parameters towards the controller
    output mbs_pkg::mbs_wr_t     set_wr_out,
    output mbs_pkg::mbs_wr_t     ctrl_cmd_out,
    input  wire logic [7:0]      set_rd_addr_in,
    output logic [15:0]          set_rd_data_out
);
    import mbs_pkg::*;

    mbs_regs_t   r_ff;
    mbs_regs_t   nxt_r;
    logic [1:0]  rst_sync_ff;
    logic        rst_n;
    logic [7:0]  rx_buf [0:255];
    logic [15:0] set_mem [0:255];

    logic        buf_we;
    logic        set_we;
    logic [7:0]  set_waddr;
    logic [15:0] set_wdata;
    logic [15:0] div;
    logic [23:0] sil_lim;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  b6;
    logic [15:0] start_addr;
    logic [15:0] qty;
    logic [16:0] end_addr;
    logic [15:0] cur_addr;
    logic [7:0]  wr_idx;
    logic        addr_ok;
    logic        crc_ok;
    logic        len_rd;
    logic        qty_rd_ok;
    logic        fn_ok;
    logic        is_read;
    logic        word_hi;
    logic        crc_byte;
    logic [7:0]  tx_byte;

    // Reset release through two flops
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    assign div        = mbs_bit_div(baud_sel_in);
    assign sil_lim    = mbs_sil_lim(div);
    assign b0         = rx_buf[0];
    assign b1         = rx_buf[1];
    assign b6         = rx_buf[6];
    assign start_addr = {rx_buf[2], rx_buf[3]};
    assign qty        = {rx_buf[4], rx_buf[5]};
    assign end_addr   = {1'b0, start_addr} + {1'b0, qty};
    assign cur_addr   = r_ff.base + {8'h00, r_ff.wi};
    assign wr_idx     = WR_DATA_FIRST + {r_ff.wi[6:0], 1'b0};

    // Own station only, and only while communication is enabled
    assign addr_ok = (station_in >= STATION_MIN) && (station_in <= STATION_MAX)
                     && (b0 == station_in);
    assign crc_ok  = (r_ff.rx_crc == CRC_RESIDUE) && !r_ff.rx_bad
                     && (r_ff.rx_len >= MIN_FRAME_LEN);
    assign len_rd    = (r_ff.rx_len == RD_REQ_LEN);
    assign qty_rd_ok = (qty != 16'h0000) && (qty <= MAX_RD_QTY);

    always_comb begin
        fn_ok = 1'b0;
        unique case (b1)
            FN_RD_INPUT: fn_ok = len_rd && qty_rd_ok && (end_addr <= REG_SPAN);
            FN_RD_HOLD:  fn_ok = len_rd && qty_rd_ok &&
                                 ((end_addr <= REG_SPAN) ||
                                  ((start_addr >= ALT_BASE) && (end_addr <= ALT_LIMIT)));
            FN_WR_ONE:   fn_ok = len_rd && ({1'b0, start_addr} < REG_SPAN);
            FN_WR_MULTI: fn_ok = (qty != 16'h0000) && (qty <= MAX_WR_QTY) &&
                                 (b6 == {qty[6:0], 1'b0}) &&
                                 (r_ff.rx_len == WR_MULTI_HDR + {qty[7:0], 1'b0}) &&
                                 (end_addr <= REG_SPAN);
            default:     fn_ok = 1'b0;
        endcase
    end

    // Reply byte selection
    assign is_read  = (r_ff.fn == FN_RD_HOLD) || (r_ff.fn == FN_RD_INPUT);
    assign crc_byte = (r_ff.tx_idx >= r_ff.resp_len - 9'h002);
    assign word_hi  = is_read && (r_ff.tx_idx >= 9'h003) && !crc_byte && r_ff.tx_idx[0];

    always_comb begin
        tx_byte = 8'h00;
        if (r_ff.tx_idx == r_ff.resp_len - 9'h002) begin
            tx_byte = r_ff.tx_crc[7:0];
        end else if (r_ff.tx_idx == r_ff.resp_len - 9'h001) begin
            tx_byte = r_ff.tx_crc[15:8];
        end else if (r_ff.tx_idx == 9'h000) begin
            tx_byte = b0;
        end else if (r_ff.tx_idx == 9'h001) begin
            tx_byte = r_ff.fn;
        end else if (is_read) begin
            if (r_ff.tx_idx == 9'h002) begin
                tx_byte = {r_ff.qty[6:0], 1'b0};
            end else begin
                tx_byte = word_hi ? r_ff.word[15:8] : r_ff.word[7:0];
            end
        end else begin
            tx_byte = rx_buf[r_ff.tx_idx[7:0]];
        end
    end

    always_comb begin
        nxt_r           = r_ff;
        nxt_r.wr.valid  = 1'b0;
        nxt_r.cmd.valid = 1'b0;
        nxt_r.rd_data   = set_mem[set_rd_addr_in];
        buf_we          = 1'b0;
        set_we          = 1'b0;
        set_waddr       = cur_addr[7:0];
        set_wdata       = 16'h0000;
        unique case (r_ff.st)
            MBS_LISTEN: begin
                if (!r_ff.rx_busy) begin
                    // Idle count saturates so a long quiet line never wraps
                    if (r_ff.sil_cnt != 24'hFFFFFF) begin
                        nxt_r.sil_cnt = r_ff.sil_cnt + 24'h000001;
                    end
                    if (!rx_in) begin
                        nxt_r.rx_busy = 1'b1;
                        nxt_r.rx_cnt  = 16'h0000;
                        nxt_r.rx_bit  = 4'h0;
                    end else if (r_ff.sil_cnt > sil_lim && r_ff.rx_len != 9'h000) begin
                        nxt_r.st = MBS_CHECK;
                    end
                end else begin
                    nxt_r.sil_cnt = 24'h000000;
                    nxt_r.rx_cnt  = r_ff.rx_cnt + 16'h0001;
                    if (r_ff.rx_bit == 4'h0) begin
                        // Start bit confirmed at its middle, else a glitch
                        if (r_ff.rx_cnt == {1'b0, div[15:1]}) begin
                            nxt_r.rx_cnt = 16'h0000;
                            if (rx_in) begin
                                nxt_r.rx_busy = 1'b0;
                            end else begin
                                nxt_r.rx_bit = 4'h1;
                            end
                        end
                    end else if (r_ff.rx_cnt == div - 16'h0001) begin
                        nxt_r.rx_cnt = 16'h0000;
                        nxt_r.rx_bit = r_ff.rx_bit + 4'h1;
                        if (r_ff.rx_bit == RX_STOP_BIT) begin
                            nxt_r.rx_busy = 1'b0;
                            nxt_r.rx_bit  = 4'h0;
                            if (!rx_in || r_ff.rx_len == RX_BUF_BYTES) begin
                                nxt_r.rx_bad = 1'b1;
                            end else begin
                                buf_we       = 1'b1;
                                nxt_r.rx_len = r_ff.rx_len + 9'h001;
                                nxt_r.rx_crc = mbs_crc_byte(r_ff.rx_crc, r_ff.rx_sh);
                            end
                        end else begin
                            nxt_r.rx_sh = {rx_in, r_ff.rx_sh[7:1]};
                        end
                    end
                end
            end
            MBS_CHECK: begin
                // Every frame end clears the receiver, accepted or not
                nxt_r.st      = MBS_LISTEN;
                nxt_r.rx_len  = 9'h000;
                nxt_r.rx_bad  = 1'b0;
                nxt_r.rx_crc  = CRC_INIT;
                nxt_r.fn      = b1;
                nxt_r.base    = start_addr;
                nxt_r.qty     = (b1 == FN_WR_ONE) ? 16'h0001 : qty;
                nxt_r.wi      = 8'h00;
                nxt_r.fetched = 1'b0;
                nxt_r.tx_idx  = 9'h000;
                nxt_r.tx_crc  = CRC_INIT;
                if (crc_ok && addr_ok && fn_ok) begin
                    if (b1 == FN_WR_ONE || b1 == FN_WR_MULTI) begin
                        nxt_r.st       = MBS_APPLY;
                        nxt_r.resp_len = WR_RESP_LEN;
                    end else begin
                        nxt_r.st       = MBS_LOAD;
                        nxt_r.tx_en    = 1'b1;
                        nxt_r.resp_len = RD_RESP_FIX + {qty[7:0], 1'b0};
                    end
                end
            end
            MBS_APPLY: begin
                // One word per cycle, all stored before the reply is driven
                set_we    = 1'b1;
                set_wdata = (r_ff.fn == FN_WR_ONE) ? {rx_buf[4], rx_buf[5]}
                                                   : {rx_buf[wr_idx], rx_buf[wr_idx + 8'h01]};
                nxt_r.wr  = '{valid: 1'b1, addr: set_waddr, data: set_wdata};
                if (set_waddr == CTRL_PARAM_ADDR) begin
                    nxt_r.cmd = '{valid: 1'b1, addr: set_waddr, data: set_wdata};
                end
                nxt_r.wi = r_ff.wi + 8'h01;
                if ({8'h00, r_ff.wi + 8'h01} == r_ff.qty) begin
                    nxt_r.st    = MBS_LOAD;
                    nxt_r.tx_en = 1'b1;
                end
            end
            MBS_LOAD: begin
                if (word_hi && !r_ff.fetched) begin
                    nxt_r.st = MBS_FETCH;
                end else begin
                    nxt_r.fetched = 1'b0;
                    nxt_r.tx_sh   = {1'b1, tx_byte, 1'b0};
                    nxt_r.tx_bit  = 4'h0;
                    nxt_r.tx_cnt  = 16'h0000;
                    if (!crc_byte) begin
                        nxt_r.tx_crc = mbs_crc_byte(r_ff.tx_crc, tx_byte);
                    end
                    nxt_r.st = MBS_SEND;
                end
            end
            MBS_FETCH: begin
                nxt_r.act_addr = cur_addr[7:0];
                nxt_r.st       = MBS_LATCH;
            end
            MBS_LATCH: begin
                // Alternate holding mapping reads the same actual data
                if (r_ff.fn == FN_RD_INPUT || cur_addr[8]) begin
                    nxt_r.word = act_data_in;
                end else begin
                    nxt_r.word = set_mem[cur_addr[7:0]];
                end
                nxt_r.fetched = 1'b1;
                nxt_r.wi      = r_ff.wi + 8'h01;
                nxt_r.st      = MBS_LOAD;
            end
            MBS_SEND: begin
                nxt_r.tx_cnt = r_ff.tx_cnt + 16'h0001;
                if (r_ff.tx_cnt == div - 16'h0001) begin
                    nxt_r.tx_cnt = 16'h0000;
                    nxt_r.tx_sh  = {1'b1, r_ff.tx_sh[9:1]};
                    nxt_r.tx_bit = r_ff.tx_bit + 4'h1;
                    if (r_ff.tx_bit == TX_FRAME_BITS - 4'h1) begin
                        if (r_ff.tx_idx == r_ff.resp_len - 9'h001) begin
                            nxt_r.st      = MBS_GUARD;
                            nxt_r.tx_en   = 1'b0;
                            nxt_r.sil_cnt = 24'h000000;
                        end else begin
                            nxt_r.tx_idx = r_ff.tx_idx + 9'h001;
                            nxt_r.st     = MBS_LOAD;
                        end
                    end
                end
            end
            MBS_GUARD: begin
                // Keep the line quiet after a reply before listening again
                nxt_r.sil_cnt = r_ff.sil_cnt + 24'h000001;
                if (r_ff.sil_cnt > sil_lim) begin
                    nxt_r.st = MBS_LISTEN;
                end
            end
        endcase
        nxt_r.tx_line = (nxt_r.st == MBS_SEND) ? nxt_r.tx_sh[0] : 1'b1;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            r_ff <= MBS_REGS_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Frame buffer and setting storage
    always_ff @(posedge sys_clk_in) begin
        if (buf_we) begin
            rx_buf[r_ff.rx_len[7:0]] <= r_ff.rx_sh;
        end
        if (set_we) begin
            set_mem[set_waddr] <= set_wdata;
        end
    end

    assign tx_out          = r_ff.tx_line;
    assign tx_en_out       = r_ff.tx_en;
    assign act_addr_out    = r_ff.act_addr;
    assign set_wr_out      = r_ff.wr;
    assign ctrl_cmd_out    = r_ff.cmd;
    assign set_rd_data_out = r_ff.rd_data;

endmodule : mbs_framer

// file: verif/mbs_framer_checker.sv
`timescale 1ns/100ps
module mbs_framer_checker
    import mbs_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rstn_in,
    // Watched ports
    input  wire logic             rx_in,
    input  wire logic             tx_out,
    input  wire logic             tx_en_out,
    input  wire logic [2:0]       baud_sel_in,
    input  wire logic [7:0]       station_in,
    input  wire mbs_pkg::mbs_wr_t set_wr_out,
    input  wire mbs_pkg::mbs_wr_t ctrl_cmd_out
);
    localparam int unsigned RATE [8] = '{2400, 4800, 9600, 19200, 38400, 57600, 115200, 9600};
    logic [31:0] div;
    logic [31:0] sil_lim;
    logic [31:0] idle_ff;
    logic [31:0] en_len_ff;

    assign div     = CLK_HZ / RATE[baud_sel_in];
    assign sil_lim = div * 77 / 2;

    // Receive-line idle time and length of the driven reply
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            idle_ff   <= '0;
            en_len_ff <= '0;
        end else begin
            idle_ff   <= rx_in ? idle_ff + 32'd1 : '0;
            en_len_ff <= tx_en_out ? en_len_ff + 32'd1 : '0;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    sequence line_quiet;
        idle_ff > sil_lim;
    endsequence
    sequence start_bit;
        ##[0:2] (tx_en_out && !tx_out);
    endsequence

    silence_before_reply_a: assert property ($rose(tx_en_out) |-> line_quiet)
        else $error("reply began without silence");
    reply_start_a: assert property ($rose(tx_en_out) |-> start_bit)
        else $error("reply did not open with a start bit");
    stop_level_a: assert property ($fell(tx_en_out) |-> $past(tx_out) && tx_out)
        else $error("driver released off a stop bit");
    idle_high_a: assert property (!tx_en_out |-> tx_out)
        else $error("line low while not driving");
    station_gate_a: assert property ($rose(tx_en_out) |->
        station_in inside {[STATION_MIN:STATION_MAX]})
        else $error("reply with station out of range");
    ctrl_pair_a: assert property (ctrl_cmd_out.valid |->
        set_wr_out == ctrl_cmd_out && ctrl_cmd_out.addr == 8'h00)
        else $error("command without matching write");
    ctrl_issue_a: assert property (set_wr_out.valid && set_wr_out.addr == 8'h00 |->
        ctrl_cmd_out.valid)
        else $error("write of parameter one gave no command");
    wr_before_reply_a: assert property (set_wr_out.valid |-> !$past(tx_en_out))
        else $error("write during reply");
    reply_length_a: assert property ($fell(tx_en_out) |-> en_len_ff >= 69 * div)
        else $error("reply shorter than minimum frame");
endmodule : mbs_framer_checker

bind mbs_framer mbs_framer_checker u_chk (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .rx_in(rx_in), .tx_out(tx_out), .tx_en_out(tx_en_out), .baud_sel_in(baud_sel_in),
    .station_in(station_in), .set_wr_out(set_wr_out), .ctrl_cmd_out(ctrl_cmd_out));

// file: verif/mbs_host_model.sv
`timescale 1ns/100ps
module mbs_host_model #(
    parameter int unsigned DIV = 434
) (
    input  wire logic sys_clk_in,
    output logic      line_out,
    input  wire logic tx_in,
    input  wire logic tx_en_in
);
    localparam int unsigned SIL = DIV * 77 / 2;
    logic wire_lvl;

    // Failsafe bias holds the undriven line high
    assign wire_lvl = tx_en_in ? tx_in : 1'b1;
    initial line_out = 1'b1;

    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
            end
        end
        return c;
    endfunction : crc16

    task automatic send_frame(input logic [7:0] q[$], input logic bad);
        logic [15:0] c;
        c = crc16(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        repeat (SIL + DIV) @(posedge sys_clk_in);
        foreach (q[i]) begin
            for (int b = 0; b < 10; b++) begin
                line_out <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : q[i][b - 1];
                repeat (DIV) @(posedge sys_clk_in);
            end
        end
    endtask : send_frame

    task automatic recv_frame(output logic [7:0] q[$], input int unsigned first_wait);
        logic [7:0]  b;
        int unsigned n;
        q = {};
        n = first_wait;
        repeat (256) begin
            while (n > 0 && wire_lvl) begin
                n--;
                @(posedge sys_clk_in);
            end
            if (wire_lvl) break;
            repeat (DIV / 2) @(posedge sys_clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (DIV) @(posedge sys_clk_in);
                b[i] = wire_lvl;
            end
            repeat (DIV) @(posedge sys_clk_in);
            q.push_back(b);
            n = 2 * DIV;
        end
    endtask : recv_frame
endmodule : mbs_host_model

// file: verif/mbs_framer_tb_top.sv
`timescale 1ns/100ps
module mbs_framer_tb_top;
    import mbs_pkg::*;
    localparam int unsigned DIV = 434;
    localparam int unsigned SIL = DIV * 77 / 2;
    logic        sys_clk_in, rstn_in, rx_in, tx_out, tx_en_out;
    logic [2:0]  baud_sel_in;
    logic [7:0]  station_in, act_addr_out, set_rd_addr_in;
    logic [15:0] act_data_in, set_rd_data_out;
    mbs_wr_t     set_wr_out, ctrl_cmd_out, wr_seen, cmd_seen;
    int          mismatches, check_count, wr_count;
    logic [7:0]  reply[$];

    mbs_framer DUT (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .rx_in(rx_in),
        .tx_out(tx_out), .tx_en_out(tx_en_out), .baud_sel_in(baud_sel_in),
        .station_in(station_in), .act_addr_out(act_addr_out), .act_data_in(act_data_in),
        .set_wr_out(set_wr_out), .ctrl_cmd_out(ctrl_cmd_out),
        .set_rd_addr_in(set_rd_addr_in), .set_rd_data_out(set_rd_data_out));
    mbs_host_model #(.DIV(DIV)) host (.sys_clk_in(sys_clk_in), .line_out(rx_in),
        .tx_in(tx_out), .tx_en_in(tx_en_out));

    // Actual-data table: high byte fixed, low byte the index
    assign act_data_in = {8'hA5, act_addr_out};

    always @(posedge sys_clk_in) begin
        if (set_wr_out.valid === 1'b1) begin
            wr_seen  <= set_wr_out;
            wr_count <= wr_count + 1;
        end
        if (ctrl_cmd_out.valid === 1'b1) cmd_seen <= ctrl_cmd_out;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic query(input logic [7:0] q[$], input logic bad);
        host.send_frame(q, bad);
        host.recv_frame(reply, SIL + 4 * DIV);
    endtask : query

    task automatic check_reply(input logic [7:0] exp[$]);
        logic [15:0] c;
        c = host.crc16(exp);
        exp.push_back(c[7:0]);
        exp.push_back(c[15:8]);
        check(reply.size(), exp.size(), "reply length");
        foreach (exp[i]) if (i < reply.size()) check(reply[i], exp[i], "reply byte");
    endtask : check_reply

    task automatic t_read_input();
        query('{8'h12, 8'h04, 8'h00, 8'h05, 8'h00, 8'h01}, 1'b0);
        check_reply('{8'h12, 8'h04, 8'h02, 8'hA5, 8'h05});
        $display("test read_input done");
    endtask : t_read_input

    task automatic t_read_alt();
        query('{8'h12, 8'h03, 8'h01, 8'h02, 8'h00, 8'h02}, 1'b0);
        check_reply('{8'h12, 8'h03, 8'h04, 8'hA5, 8'h02, 8'hA5, 8'h03});
        $display("test read_alt done");
    endtask : t_read_alt

    task automatic t_write_ctrl();
        int n0;
        n0 = wr_count;
        query('{8'h12, 8'h06, 8'h00, 8'h00, 8'h12, 8'h34}, 1'b0);
        check_reply('{8'h12, 8'h06, 8'h00, 8'h00, 8'h12, 8'h34});
        check(wr_count - n0, 1, "write count");
        check(wr_seen, {1'b1, 8'h00, 16'h1234}, "setting write");
        check(cmd_seen, {1'b1, 8'h00, 16'h1234}, "control command");
        set_rd_addr_in <= 8'h00;
        repeat (2) @(posedge sys_clk_in);
        check(set_rd_data_out, 16'h1234, "stored setting");
        // No station number is queried again after a store to it
        station_in <= 8'h13;
        n0 = wr_count;
        query('{8'h13, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04,
                8'hAB, 8'hCD, 8'h00, 8'h11}, 1'b0);
        check_reply('{8'h13, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02});
        check(wr_count - n0, 2, "multi write count");
        check(wr_seen, {1'b1, 8'h02, 16'h0011}, "last multi write");
        station_in <= 8'h14;
        query('{8'h14, 8'h03, 8'h00, 8'h00, 8'h00, 8'h03}, 1'b0);
        check_reply('{8'h14, 8'h03, 8'h06, 8'h12, 8'h34, 8'hAB, 8'hCD, 8'h00, 8'h11});
        $display("test write_ctrl done");
    endtask : t_write_ctrl

    task automatic t_gap();
        host.send_frame('{8'h12, 8'h04, 8'h00}, 1'b1);
        query('{8'h12, 8'h04, 8'h00, 8'h07, 8'h00, 8'h01}, 1'b0);
        check_reply('{8'h12, 8'h04, 8'h02, 8'hA5, 8'h07});
        $display("test gap done");
    endtask : t_gap

    task automatic t_refuse();
        // Station setting, frame station, function, corrupt CRC
        logic [31:0] cases[5] = '{32'h1212_0601, 32'h1200_0600, 32'h1209_0600,
                                  32'hF8F8_0600, 32'h1212_0500};
        int          n0;
        int          busy;
        foreach (cases[i]) begin
            station_in <= cases[i][31:24];
            n0 = wr_count;
            busy = 0;
            host.send_frame('{cases[i][23:16], cases[i][15:8], 8'h00, 8'h01, 8'hBE, 8'hEF},
                            cases[i][0]);
            repeat (SIL + 4 * DIV) begin
                @(posedge sys_clk_in);
                busy += (tx_en_out !== 1'b0);
            end
            check(busy, 0, "refused frame drove line");
            check(wr_count - n0, 0, "refused frame wrote");
        end
        station_in <= 8'h12;
        $display("test refuse done");
    endtask : t_refuse

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    initial begin
        rstn_in = 1'b0;
        baud_sel_in = 3'h6;
        station_in = 8'h12;
        set_rd_addr_in = 8'h00;
        mismatches = 0;
        check_count = 0;
        repeat (3) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        t_read_input();
        t_read_alt();
        t_gap();
        t_refuse();
        t_write_ctrl();
        end_of_test();
    end
endmodule : mbs_framer_tb_top
